// ===== verilog/timer_unit.sv
// timer unit: four general timers, one wake-up timer, standby control, register port
// assumes a same-clock register master and a slow oscillator arriving on a pin
//
// Operation
// - the wake-up timer brings the system out of standby when its interval runs out.
// - with auto standby reentry set, a timed wake-up that finds no card returns to standby.
// - the wake-up timer counts only on ticks of the slow oscillator.
// - with reentry clear, a wake-up that finds no card stays fully powered.
// - a started timer decrements from the reload value written by software.
// - a stop event halts the timer and keeps the value reached.
// - a one-shot timer raises its interrupt once its time has elapsed.
// - with auto reload set a timer raises an interrupt at the end of every period.
// - each timer holds a 16-bit counter that decrements once per selected tick.
// - a running timer at zero sets its interrupt flag on the next tick.
// - at zero a timer either stops or reloads, as configured.
// - a general timer ticks at 13.56 MHz, 212 kHz or on wake-up timer underflow.
//
// Implementation choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
module timer_unit
  import timer_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [7:0]        addr,
  input  wire logic [31:0]       wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [31:0]       rdata,
  input  wire logic [NUM_CH-1:0] stop_event,
  input  wire logic              slow_osc_clk,
  input  wire logic              sense_done,
  input  wire logic              card_found,
  output logic                   sense_start,
  output logic                   standby,
  output logic                   irq
);

  // ****************************************
  // tick sources
  // ****************************************
  logic fast_tick;
  logic slow_tick;
  logic osc_s1_r;
  logic osc_s2_r;
  logic osc_s3_r;
  logic osc_tick;

  tick_gen #(
    .INC (FAST_INC),
    .MOD (FAST_MOD)
  ) u_fast (
    .clk  (clk),
    .rst  (rst),
    .tick (fast_tick)
  );

  tick_gen #(
    .INC (SLOW_INC),
    .MOD (SLOW_MOD)
  ) u_slow (
    .clk  (clk),
    .rst  (rst),
    .tick (slow_tick)
  );

  // slow oscillator is asynchronous: two flops, then edge detect on the second
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      osc_s1_r <= 1'b0;
      osc_s2_r <= 1'b0;
      osc_s3_r <= 1'b0;
    end else begin
      osc_s1_r <= slow_osc_clk;
      osc_s2_r <= osc_s1_r;
      osc_s3_r <= osc_s2_r;
    end
  end

  assign osc_tick = osc_s2_r & ~osc_s3_r;

  // ****************************************
  // register write decode
  // ****************************************
  logic [3:0]        cfg_r    [NUM_CH];
  logic [15:0]       reload_r [NUM_CH];
  logic [15:0]       count_w  [NUM_CH];
  logic [NUM_CH-1:0] run_w;
  logic [NUM_CH-1:0] under_w;
  logic [NUM_CH-1:0] start_w;
  logic [NUM_CH-1:0] stop_w;
  logic [NUM_CH-1:0] ch_tick;
  logic [2:0]        wk_ctrl_r;
  logic [15:0]       wk_reload_r;
  logic [15:0]       wk_count;
  logic              wk_running;
  logic              wk_under;
  logic              wk_start;
  logic              wk_stop;
  logic [IRQ_W-1:0]  irq_stat_r;
  logic [IRQ_W-1:0]  irq_mask_r;
  logic [IRQ_W-1:0]  irq_set;
  logic              card_evt;
  logic              stby_cmd;
  pwr_state_t        pwr_r;

  logic wr_tctrl;
  logic wr_wk_ctrl;

  assign wr_tctrl   = wr && (addr == OFS_TCTRL);
  assign wr_wk_ctrl = wr && (addr == OFS_WK_CTRL);
  assign stby_cmd   = wr && (addr == OFS_POWER) && wdata[PWR_STBY_BIT];

  // ****************************************
  // general timers
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
      localparam logic [7:0] CH_BASE = 8'(OFS_CH_BASE + OFS_CH_STRIDE * gi);

      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          cfg_r[gi]    <= CFG_RST;
          reload_r[gi] <= RELOAD_RST;
        end else if (wr) begin
          if (addr == CH_BASE + OFS_CH_CFG) begin
            cfg_r[gi] <= wdata[3:0];
          end
          if (addr == CH_BASE + OFS_CH_RELOAD) begin
            reload_r[gi] <= wdata[15:0];
          end
        end
      end

      always_comb begin
        case (cfg_r[gi][CFG_SEL_LSB +: 2])
          SEL_FAST:   ch_tick[gi] = fast_tick;
          SEL_SLOW:   ch_tick[gi] = slow_tick;
          SEL_WAKEUP: ch_tick[gi] = wk_under;
          default:    ch_tick[gi] = 1'b0;
        endcase
      end

      // start/stop now: bit in the upper nibble picks the timer, lower nibble says run or halt
      assign start_w[gi] = wr_tctrl && wdata[TCTRL_NOW_LSB + gi] && wdata[gi];
      assign stop_w[gi]  = (wr_tctrl && wdata[TCTRL_NOW_LSB + gi] && !wdata[gi])
                         || (cfg_r[gi][CFG_STOPEN_BIT] && stop_event[gi]);

      down_counter u_cnt (
        .clk           (clk),
        .rst           (rst),
        .start         (start_w[gi]),
        .stop          (stop_w[gi]),
        .tick          (ch_tick[gi]),
        .auto_reload   (cfg_r[gi][CFG_AUTO_BIT]),
        .reload_value  (reload_r[gi]),
        .running       (run_w[gi]),
        .counter_value (count_w[gi]),
        .underflow     (under_w[gi])
      );
    end
  endgenerate

  // ****************************************
  // wake-up timer
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wk_ctrl_r   <= WK_RST;
      wk_reload_r <= RELOAD_RST;
    end else if (wr) begin
      if (addr == OFS_WK_CTRL) begin
        wk_ctrl_r <= wdata[2:0];
      end
      if (addr == OFS_WK_RELOAD) begin
        wk_reload_r <= wdata[15:0];
      end
    end
  end

  assign wk_start = wr_wk_ctrl && wdata[WK_RUN_BIT];
  assign wk_stop  = wr_wk_ctrl && !wdata[WK_RUN_BIT];

  down_counter u_wake (
    .clk           (clk),
    .rst           (rst),
    .start         (wk_start),
    .stop          (wk_stop),
    .tick          (osc_tick),
    .auto_reload   (wk_ctrl_r[WK_AUTO_BIT]),
    .reload_value  (wk_reload_r),
    .running       (wk_running),
    .counter_value (wk_count),
    .underflow     (wk_under)
  );

  // ****************************************
  // standby and card sensing
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pwr_r       <= PWR_AWAKE;
      sense_start <= 1'b0;
      card_evt    <= 1'b0;
    end else begin
      sense_start <= 1'b0;
      card_evt    <= 1'b0;
      case (pwr_r)
        PWR_AWAKE: begin
          if (stby_cmd) begin
            pwr_r <= PWR_STANDBY;
          end
        end
        PWR_STANDBY: begin
          if (wk_under) begin
            pwr_r       <= PWR_SENSE;
            sense_start <= 1'b1;
          end
        end
        PWR_SENSE: begin
          if (sense_done) begin
            if (card_found) begin
              pwr_r    <= PWR_AWAKE;
              card_evt <= 1'b1;
            end else if (wk_ctrl_r[WK_REENTRY_BIT]) begin
              pwr_r <= PWR_STANDBY;
            end else begin
              pwr_r <= PWR_AWAKE;
            end
          end
        end
        default: pwr_r <= PWR_AWAKE;
      endcase
    end
  end

  // timers keep running in standby; only the outside world is powered down
  assign standby = (pwr_r == PWR_STANDBY);

  // ****************************************
  // interrupts
  // ****************************************
  assign irq_set = {card_evt, wk_under, under_w};

  // a set arriving with its clear wins, so no underflow is lost
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_stat_r <= IRQ_RST;
    end else if (wr && addr == OFS_IRQ_STAT) begin
      irq_stat_r <= (irq_stat_r & ~wdata[IRQ_W-1:0]) | irq_set;
    end else begin
      irq_stat_r <= irq_stat_r | irq_set;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_mask_r <= IRQ_RST;
    end else if (wr && addr == OFS_IRQ_MASK) begin
      irq_mask_r <= wdata[IRQ_W-1:0];
    end
  end

  assign irq = |(irq_stat_r & irq_mask_r);

  // ****************************************
  // register read
  // ****************************************
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h0000_0000;
    for (int i = 0; i < NUM_CH; i++) begin
      if (addr == 8'(OFS_CH_BASE + OFS_CH_STRIDE * i) + OFS_CH_CFG) begin
        rd_mux = {28'h0000000, cfg_r[i]};
      end
      if (addr == 8'(OFS_CH_BASE + OFS_CH_STRIDE * i) + OFS_CH_RELOAD) begin
        rd_mux = {16'h0000, reload_r[i]};
      end
      if (addr == 8'(OFS_CH_BASE + OFS_CH_STRIDE * i) + OFS_CH_COUNT) begin
        rd_mux = {16'h0000, count_w[i]};
      end
    end
    case (addr)
      OFS_TCTRL:     rd_mux = {28'h0000000, run_w};
      OFS_WK_CTRL:   rd_mux = {28'h0000000, wk_running, wk_ctrl_r};
      OFS_WK_RELOAD: rd_mux = {16'h0000, wk_reload_r};
      OFS_WK_COUNT:  rd_mux = {16'h0000, wk_count};
      OFS_IRQ_STAT:  rd_mux = {26'h0, irq_stat_r};
      OFS_IRQ_MASK:  rd_mux = {26'h0, irq_mask_r};
      OFS_POWER:     rd_mux = {30'h0, pwr_r == PWR_SENSE, standby};
      default:       rd_mux = rd_mux;
    endcase
  end

  // unmapped addresses read as zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= 32'h0000_0000;
    end else if (rd) begin
      rdata <= rd_mux;
    end else begin
      rdata <= 32'h0000_0000;
    end
  end

endmodule // timer_unit

// ===== inc/timer_pkg.sv
// timer unit package: register map, field positions, reset values, tick rates
// assumes a 20 MHz system clock and an 8-bit word address space
package timer_pkg;

  // ****************************************
  // clock and tick rates
  // ****************************************
  localparam int unsigned SYS_CLK_KHZ  = 20000;
  localparam int unsigned FAST_TICK_KHZ = 13560;
  localparam int unsigned SLOW_TICK_KHZ = 212;
  localparam logic [15:0] FAST_INC = 16'(FAST_TICK_KHZ / 10);
  localparam logic [15:0] FAST_MOD = 16'(SYS_CLK_KHZ / 10);
  localparam logic [15:0] SLOW_INC = 16'(SLOW_TICK_KHZ);
  localparam logic [15:0] SLOW_MOD = 16'(SYS_CLK_KHZ);

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] OFS_TCTRL     = 8'h00;
  localparam logic [7:0] OFS_CH_BASE   = 8'h10;
  localparam logic [7:0] OFS_CH_STRIDE = 8'h10;
  localparam logic [7:0] OFS_CH_CFG    = 8'h00;
  localparam logic [7:0] OFS_CH_RELOAD = 8'h04;
  localparam logic [7:0] OFS_CH_COUNT  = 8'h08;
  localparam logic [7:0] OFS_WK_CTRL   = 8'h50;
  localparam logic [7:0] OFS_WK_RELOAD = 8'h54;
  localparam logic [7:0] OFS_WK_COUNT  = 8'h58;
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h60;
  localparam logic [7:0] OFS_IRQ_MASK  = 8'h64;
  localparam logic [7:0] OFS_POWER     = 8'h68;

  // ****************************************
  // field positions and sizes
  // ****************************************
  localparam int NUM_CH        = 4;
  localparam int IRQ_W         = 6;
  localparam int TCTRL_NOW_LSB = 4;
  localparam int CFG_SEL_LSB   = 0;
  localparam int CFG_AUTO_BIT  = 2;
  localparam int CFG_STOPEN_BIT = 3;
  localparam int WK_RUN_BIT    = 0;
  localparam int WK_REENTRY_BIT = 1;
  localparam int WK_AUTO_BIT   = 2;
  localparam int IRQ_WAKE_BIT  = 4;
  localparam int IRQ_CARD_BIT  = 5;
  localparam int PWR_STBY_BIT  = 0;

  localparam logic [1:0] SEL_FAST   = 2'h0;
  localparam logic [1:0] SEL_SLOW   = 2'h1;
  localparam logic [1:0] SEL_WAKEUP = 2'h2;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [15:0] RELOAD_RST = 16'h0000;
  localparam logic [3:0]  CFG_RST    = 4'h0;
  localparam logic [2:0]  WK_RST     = 3'h0;
  localparam logic [IRQ_W-1:0] IRQ_RST = 6'h00;

  typedef enum logic [1:0] {PWR_AWAKE, PWR_STANDBY, PWR_SENSE} pwr_state_t;

endpackage

// ===== verilog/tick_gen.sv
// fractional tick generator: one-cycle tick at an average rate of INC/MOD of clk
// assumes INC below MOD
`timescale 1ns/1ps
module tick_gen
  import timer_pkg::*;
#(
  parameter logic [15:0] INC = 16'h0001,
  parameter logic [15:0] MOD = 16'h0002
) (
  input  wire logic clk,
  input  wire logic rst,
  output logic      tick
);

  logic [15:0] acc_r;
  logic [16:0] sum;

  // phase accumulator keeps the average rate exact; jitter is one clk
  assign sum = {1'b0, acc_r} + {1'b0, INC};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_r <= 16'h0000;
      tick  <= 1'b0;
    end else if (sum >= {1'b0, MOD}) begin
      acc_r <= 16'(sum - {1'b0, MOD});
      tick  <= 1'b1;
    end else begin
      acc_r <= sum[15:0];
      tick  <= 1'b0;
    end
  end

endmodule // tick_gen

// ===== verilog/down_counter.sv
// one 16-bit down-counting timer channel with reload, stop and underflow pulse
// assumes start and stop are one-cycle pulses on clk; start wins over stop
`timescale 1ns/1ps
module down_counter
  import timer_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        start,
  input  wire logic        stop,
  input  wire logic        tick,
  input  wire logic        auto_reload,
  input  wire logic [15:0] reload_value,
  output logic             running,
  output logic [15:0]      counter_value,
  output logic             underflow
);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      running       <= 1'b0;
      counter_value <= 16'h0000;
      underflow     <= 1'b0;
    end else begin
      underflow <= 1'b0;
      if (start) begin
        running       <= 1'b1;
        counter_value <= reload_value;
      end else if (stop) begin
        running <= 1'b0;
      end else if (running && tick) begin
        if (counter_value == 16'h0000) begin
          underflow <= 1'b1;
          if (auto_reload) begin
            counter_value <= reload_value;
          end else begin
            running <= 1'b0;
          end
        end else begin
          counter_value <= counter_value - 16'h0001;
        end
      end
    end
  end

endmodule // down_counter

// ===== testbench/timer_unit_monitor.sv
// checker of timer_unit port behaviour: read slot, standby moves, interrupt level
// assumes binding onto timer_unit and a single clock domain
`timescale 1ns/1ps
module timer_unit_monitor
  import timer_pkg::*;
(
  input wire logic              clk,
  input wire logic              rst,
  input wire logic [7:0]        addr,
  input wire logic [31:0]       wdata,
  input wire logic              wr,
  input wire logic              rd,
  input wire logic [31:0]       rdata,
  input wire logic [NUM_CH-1:0] stop_event,
  input wire logic              slow_osc_clk,
  input wire logic              sense_done,
  input wire logic              card_found,
  input wire logic              sense_start,
  input wire logic              standby,
  input wire logic              irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ********
  // assertions
  // ********
  a_read_slot: assert property (rdata != 32'h0 |-> $past(rd))
    else $error("read data outside its slot");
  a_upper_zero: assert property ($past(rd) |-> rdata[31:16] == 16'h0)
    else $error("upper read bits not zero");
  a_sense_pulse: assert property (sense_start |=> !sense_start)
    else $error("sense start longer than one cycle");
  a_wake_source: assert property (sense_start |-> $past(standby) && !standby)
    else $error("sense start without leaving standby");
  a_leave_standby: assert property ($fell(standby) |-> sense_start)
    else $error("standby left without wake-up");
  a_enter_standby: assert property ($rose(standby) |-> $past(wr) || $past(sense_done))
    else $error("standby entered without cause");
  a_card_awake: assert property (sense_done && card_found && !standby && !wr |=> !standby)
    else $error("standby entered although a card was found");
  a_irq_held: assert property (irq && !wr |=> irq)
    else $error("interrupt dropped without a write");
  // a wake-up that re-enters standby is the low power sensing loop
  c_sense: cover property (sense_start);
  c_irq: cover property ($rose(irq));
  c_reentry: cover property ($rose(standby) && $past(sense_done));
endmodule // timer_unit_monitor

bind timer_unit timer_unit_monitor monitor (
  .clk(clk),
  .rst(rst),
  .addr(addr),
  .wdata(wdata),
  .wr(wr),
  .rd(rd),
  .rdata(rdata),
  .stop_event(stop_event),
  .slow_osc_clk(slow_osc_clk),
  .sense_done(sense_done),
  .card_found(card_found),
  .sense_start(sense_start),
  .standby(standby),
  .irq(irq)
);

// ===== testbench/tb_timer_unit.sv
// self-checking bench for timer_unit: registers, timers, standby and interrupt
// assumes a free-running slow oscillator pin and a same-clock register master
`timescale 1ns/1ps
module tb_timer_unit
  import timer_pkg::*;
;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic [7:0]        addr = 8'h00;
  logic [31:0]       wdata = 32'h0;
  logic              wr = 1'b0;
  logic              rd = 1'b0;
  logic [NUM_CH-1:0] stop_event = 4'h0;
  logic              slow_osc_clk = 1'b0;
  logic              sense_done = 1'b0;
  logic              card_found = 1'b0;
  logic [31:0]       rdata;
  logic              sense_start;
  logic              standby;
  logic              irq;
  int                miscompares = 0;
  int                checks_done = 0;
  logic [31:0]       d;
  logic [31:0]       c;
  logic [15:0]       rl;
  int                n;
  int                e;

  always #25 clk = ~clk;
  // slow oscillator runs free, unrelated to clk: 12 clk per tick
  always #300 slow_osc_clk = ~slow_osc_clk;

  timer_unit dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .stop_event(stop_event), .slow_osc_clk(slow_osc_clk), .sense_done(sense_done), .card_found(card_found),
    .sense_start(sense_start), .standby(standby), .irq(irq));

  // ********
  // bus, checks and expectations
  // ********
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= v;
    @(posedge clk);
    wr    <= 1'b0;
    #1;
  endtask
  task automatic reg_rd(input logic [7:0] a);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic pulse_done(input logic card);
    @(posedge clk);
    sense_done <= 1'b1;
    card_found <= card;
    @(posedge clk);
    sense_done <= 1'b0;
    #1;
  endtask
  // bounded wait on irq (0) or sense_start (1), cycles left in n
  task automatic wait_for(input int which);
    n = 0;
    while ((which ? sense_start : irq) !== 1'b1 && n < 3000) begin
      @(posedge clk);
      #1;
      n++;
    end
    // a wait that runs out is a failure in its own right
    if (n >= 3000) begin
      miscompares++;
    end
  endtask
  function automatic logic [7:0] ch(input int i, input logic [7:0] o);
    return OFS_CH_BASE + OFS_CH_STRIDE * 8'(i) + o;
  endfunction
  function automatic int to_ticks(input int cyc);
    return cyc * int'(FAST_INC) / int'(FAST_MOD);
  endfunction
  function automatic int to_cyc(input int ticks);
    return ticks * int'(FAST_MOD) / int'(FAST_INC);
  endfunction
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    end_sim();
  end

  // ********
  // tests
  // ********
  initial begin
    void'($urandom(32'hD8390794));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      reg_rd(ch(i % 4, (i < 4) ? OFS_CH_CFG : OFS_CH_RELOAD));
      chk(d, 32'h0);
    end
    reg_wr(8'hF0, $urandom());
    reg_rd(8'hF0);
    chk(d, 32'h0);
    reg_wr(ch(0, OFS_CH_COUNT), $urandom());
    reg_rd(ch(0, OFS_CH_COUNT));
    chk(d, 32'h0);
    $display("test registers done");
    // stopwatch: fast clock, stop event enabled
    rl = 16'h4000 | 16'($urandom() & 32'h0FFF);
    reg_wr(ch(0, OFS_CH_CFG), 32'h8);
    reg_wr(ch(0, OFS_CH_RELOAD), {16'h0, rl});
    reg_wr(OFS_TCTRL, 32'h11);
    n = 40 + $urandom() % 60;
    repeat (n) @(posedge clk);
    stop_event <= 4'h1;
    @(posedge clk);
    stop_event <= 4'h0;
    reg_rd(ch(0, OFS_CH_COUNT));
    c = d;
    e = rl - d[15:0];
    chk(e inside {[to_ticks(n + 1) - 3 : to_ticks(n + 1) + 2]}, 32'h1);
    reg_rd(OFS_IRQ_STAT);
    chk(d[0], 1'b0);
    repeat (20) @(posedge clk);
    reg_rd(ch(0, OFS_CH_COUNT));
    chk(d, c);
    reg_rd(OFS_TCTRL);
    chk(d[0], 1'b0);
    $display("test stopwatch done");
    // one-shot with the interrupt masked first
    rl = 16'(1 + $urandom() % 20);
    reg_wr(ch(1, OFS_CH_RELOAD), {16'h0, rl});
    reg_wr(OFS_TCTRL, 32'h22);
    repeat (60) @(posedge clk);
    #1;
    chk(irq, 1'b0);
    reg_rd(OFS_IRQ_STAT);
    chk(d, 32'h2);
    reg_rd(ch(1, OFS_CH_COUNT));
    chk(d, 32'h0);
    reg_rd(OFS_TCTRL);
    chk(d[1], 1'b0);
    reg_wr(OFS_IRQ_MASK, 32'h2);
    chk(irq, 1'b1);
    reg_wr(OFS_IRQ_STAT, 32'h2);
    chk(irq, 1'b0);
    // slow tick source, stopped long before it could run out
    reg_wr(ch(1, OFS_CH_CFG), 32'h1);
    reg_wr(ch(1, OFS_CH_RELOAD), 32'h100);
    reg_wr(OFS_TCTRL, 32'h22);
    repeat (470) @(posedge clk);
    reg_wr(OFS_TCTRL, 32'h20);
    reg_rd(ch(1, OFS_CH_COUNT));
    n = 471 * int'(SLOW_INC) / int'(SLOW_MOD);
    e = 256 - int'(d[15:0]);
    chk(e inside {[n - 1 : n + 1]}, 32'h1);
    $display("test one-shot done");
    // periodic: auto reload, period measured between interrupts
    rl = 16'(2 + $urandom() % 8);
    reg_wr(ch(2, OFS_CH_CFG), 32'h4);
    reg_wr(ch(2, OFS_CH_RELOAD), {16'h0, rl});
    reg_wr(OFS_IRQ_MASK, 32'h4);
    reg_wr(OFS_TCTRL, 32'h44);
    wait_for(0);
    chk(irq, 1'b1);
    reg_wr(OFS_IRQ_STAT, 32'h4);
    wait_for(0);
    e = to_cyc(rl + 1);
    chk(n inside {[e - 5 : e + 2]}, 32'h1);
    reg_wr(OFS_TCTRL, 32'h40);
    reg_wr(OFS_IRQ_STAT, 32'h4);
    reg_rd(OFS_TCTRL);
    chk(d[2], 1'b0);
    $display("test periodic done");
    // timer clocked by wake-up underflow, wake-up on slow ticks only
    reg_wr(ch(3, OFS_CH_CFG), 32'h2);
    reg_wr(ch(3, OFS_CH_RELOAD), 32'h1);
    reg_wr(OFS_WK_RELOAD, 32'h1);
    reg_wr(OFS_IRQ_MASK, 32'h8);
    reg_wr(OFS_WK_CTRL, 32'h5);
    reg_wr(OFS_TCTRL, 32'h88);
    wait_for(0);
    chk(irq, 1'b1);
    chk(n >= 20, 32'h1);
    reg_rd(OFS_IRQ_STAT);
    chk(d[4], 1'b1);
    reg_wr(OFS_TCTRL, 32'h80);
    reg_wr(OFS_IRQ_STAT, 32'h3F);
    $display("test wake clock done");
    // standby, wake-up, reentry and card found
    reg_wr(OFS_IRQ_MASK, 32'h20);
    reg_wr(OFS_WK_CTRL, 32'h7);
    reg_wr(OFS_POWER, 32'h1);
    chk(standby, 1'b1);
    wait_for(1);
    chk(sense_start, 1'b1);
    chk(standby, 1'b0);
    pulse_done(1'b0);
    chk(standby, 1'b1);
    wait_for(1);
    pulse_done(1'b1);
    chk(standby, 1'b0);
    // the card flag lands one edge after the sensing result
    @(posedge clk);
    #1;
    chk(irq, 1'b1);
    reg_wr(OFS_IRQ_STAT, 32'h3F);
    reg_wr(OFS_WK_CTRL, 32'h5);
    reg_wr(OFS_POWER, 32'h1);
    wait_for(1);
    pulse_done(1'b0);
    repeat (30) @(posedge clk);
    #1;
    chk(standby, 1'b0);
    $display("test standby done");
    end_sim();
  end
endmodule // tb_timer_unit
